// file: bench/tdmsp_chk.sv
// axi4-lite handshake and response checks of the tdm serial port
module tdmsp_chk (
  input logic                      clock,
  input logic                      rst_n,
  input tdmsp_pkg::tdmsp_axi_req_t axi_req,
  input tdmsp_pkg::tdmsp_axi_rsp_t axi_rsp,
  input logic                      tx_serial_oe,
  input logic                      generated_bit_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  import tdmsp_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // handshakes as the slave sees them
  wire aw_hs = axi_req.awvalid && axi_rsp.awready;
  wire w_hs  = axi_req.wvalid && axi_rsp.wready;
  wire ar_hs = axi_req.arvalid && axi_rsp.arready;
  a_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped early");
  a_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped early");
  a_write_answer: assert property (aw_hs && w_hs |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (ar_hs |=> axi_rsp.rvalid)
    else $error("read data late");
  a_read_blocks: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("address taken while read data pending");
  a_write_blocks: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  a_ready_back: assert property (axi_rsp.bvalid && axi_req.bready |=> ##[0:1] axi_rsp.awready)
    else $error("write address channel not reopened");
  a_unmapped_read: assert property (ar_hs && axi_req.araddr > OFS_STATUS |=>
    axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0) else $error("unmapped read not refused");
  // main scenarios reached
  c_write: cover property (aw_hs && w_hs);
  c_read: cover property (ar_hs);
  c_oe: cover property ($rose(tx_serial_oe));
  c_gclk: cover property ($rose(generated_bit_clock));
endmodule

bind tdmsp_top tdmsp_chk u_chk (
  .clock               (clock),
  .rst_n               (rst_n),
  .axi_req             (axi_req),
  .axi_rsp             (axi_rsp),
  .tx_serial_oe        (tx_serial_oe),
  .generated_bit_clock (generated_bit_clock)
);

// file: bench/tdmsp_peer.sv
// behavioural tdm bus peer: source clock, frame sync and receive data
module tdmsp_peer (
  input  logic fs_go,
  output logic src_clk,
  output logic fs_pin,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial src_clk = 1'b0;
  initial rxd = 1'b0;
  initial fs_pin = 1'b0;
  // source clock runs free, sixteen system clocks a period
  always #80 src_clk = ~src_clk;
  // data flips on every rising source edge so a stale bit never looks right
  always @(posedge src_clk) rxd <= ~rxd;
  // frame sync moves on the rising source edge and lasts whole periods
  always @(posedge src_clk) fs_pin <= fs_go;
endmodule

// file: bench/tdmsp_top_tb.sv
// self-checking bench: registers, bit clock generator, resync and channel gating
module tdmsp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tdmsp_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic [1:0]  resp;
  } tdmsp_row_t;
  typedef struct packed {
    logic [31:0] mc;
    logic [31:0] chen;
    logic [1:0]  exp;
  } tdmsp_case_t;
  logic           clock = 1'b0;
  logic           rst_n = 1'b0;
  logic           fs_go = 1'b0;
  logic           src_clk;
  logic           fs_pin;
  logic           rxd;
  logic           tx_serial_out_pin;
  logic           tx_serial_oe;
  logic           generated_bit_clock;
  tdmsp_axi_req_t req = '0;
  tdmsp_axi_rsp_t rsp;
  int             bad_count = 0;
  int             comparisons = 0;
  int             n;
  logic [31:0]    q;
  logic [1:0]     r;
  // register rows: reset values first, then access kinds
  tdmsp_row_t rows [22] = '{
    '{0, OFS_CFG, 0, 0, RESP_OKAY}, '{0, OFS_RX_MC, 0, 0, RESP_OKAY},
    '{0, OFS_TX_MC, 0, 0, RESP_OKAY}, '{0, OFS_RX_CHEN, 0, 0, RESP_OKAY},
    '{0, OFS_TX_CHEN, 0, 0, RESP_OKAY}, '{0, OFS_RX_DATA, 0, 0, RESP_OKAY},
    '{0, OFS_STATUS, 0, 32'h6, RESP_OKAY}, '{1, OFS_CFG, 32'h03EFFFFF, 0, RESP_OKAY},
    '{0, OFS_CFG, 0, 32'h03EFFFFF, RESP_OKAY}, '{1, OFS_CFG, 0, 0, RESP_OKAY},
    '{1, OFS_RX_MC, 32'h1FF, 0, RESP_OKAY}, '{0, OFS_RX_MC, 0, 32'h1E1, RESP_OKAY},
    '{1, OFS_TX_MC, 32'h1FF, 0, RESP_OKAY}, '{0, OFS_TX_MC, 0, 32'h1E3, RESP_OKAY},
    '{1, OFS_RX_CHEN, 32'hA5A55A5A, 0, RESP_OKAY}, '{0, OFS_RX_CHEN, 0, 32'hA5A55A5A, RESP_OKAY},
    '{1, OFS_TX_CHEN, 32'h5A5AA5A5, 0, RESP_OKAY}, '{0, OFS_TX_CHEN, 0, 32'h5A5AA5A5, RESP_OKAY},
    '{1, 8'h20, 32'hFFFF, 0, RESP_SLVERR}, '{0, 8'h20, 0, 0, RESP_SLVERR},
    '{1, OFS_RX_DATA, 32'h77, 0, RESP_OKAY}, '{0, OFS_RX_DATA, 0, 0, RESP_OKAY}};
  logic [31:0] pcfg [5] = '{32'h80, 32'h180, 32'h400000, 32'h400080, 32'h600000};
  int pexp [5] = '{2, 4, 16, 32, 16};
  tdmsp_case_t rxc [4] = '{'{1'b0, 0, 2'h1}, '{1, 0, 2'h0}, '{1, 1, 2'h1}, '{1, 32'h10000, 2'h0}};
  tdmsp_case_t txc [6] = '{'{TXM_ALL, 0, 2'h3}, '{TXM_SEL, 0, 2'h0}, '{TXM_MASKED, 0, 2'h1},
    '{TXM_SEL, 1, 2'h3}, '{TXM_MASKED, 1, 2'h3}, '{TXM_SYMM, 1, 2'h0}};
  always #5 clock = ~clock;
  tdmsp_top dut (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .axi_req               (req),
    .axi_rsp               (rsp),
    .external_source_clock (src_clk),
    .shift_clock_pin       (src_clk),
    .rx_frame_sync_pin     (fs_pin),
    .rx_serial_in_pin      (rxd),
    .tx_serial_out_pin     (tx_serial_out_pin),
    .tx_serial_oe          (tx_serial_oe),
    .generated_bit_clock   (generated_bit_clock)
  );
  tdmsp_peer peer (.fs_go(fs_go), .src_clk(src_clk), .fs_pin(fs_pin), .rxd(rxd));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask
  // one axi4-lite transfer; readiness is judged just before the edge that takes it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] resp);
    logic ha;
    logic hw;
    logic hr;
    int   k;
    hr = 1'b0;
    @(posedge clock);
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.arvalid <= !wr;
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    for (k = 0; !hr; k++) begin
      @(negedge clock);
      ha = wr ? req.awvalid && rsp.awready : req.arvalid && rsp.arready;
      hw = req.wvalid && rsp.wready;
      hr = wr ? rsp.bvalid && req.bready : rsp.rvalid && req.rready;
      rd = rsp.rdata;
      resp = wr ? rsp.bresp : rsp.rresp;
      @(posedge clock);
      if (ha) req.awvalid <= 1'b0;
      if (ha) req.arvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (hr) req.bready <= 1'b0;
      if (hr) req.rready <= 1'b0;
      // answer ready raised late so the slave must hold its response
      if (k == 2) req.bready <= wr;
      if (k == 2) req.rready <= !wr;
      if (k > 50) bad_count++;
      if (k > 50) summarize();
    end
  endtask
  // cycles until the bit clock has gone low and then high again
  task automatic edge_wait(output int c);
    for (c = 0; c < 900 && generated_bit_clock !== 1'b0; c++) @(negedge clock);
    for (; c < 900 && generated_bit_clock !== 1'b1; c++) @(negedge clock);
    if (c >= 900) bad_count++;
    if (c >= 900) summarize();
  endtask
  task automatic fs_pulse();
    fs_go <= 1'b1;
    repeat (40) @(posedge clock);
    fs_go <= 1'b0;
    repeat (40) @(posedge clock);
  endtask
  // program one gating case, clear the ready flag, then watch flag and output enable
  task automatic run_case(input logic tx, input tdmsp_case_t c);
    logic [1:0] seen;
    int         i;
    seen = 2'h0;
    bus(1'b1, tx ? OFS_TX_MC : OFS_RX_MC, c.mc, q, r);
    bus(1'b1, tx ? OFS_TX_CHEN : OFS_RX_CHEN, c.chen, q, r);
    bus(tx, tx ? OFS_TX_DATA : OFS_RX_DATA, 32'h96, q, r);
    repeat (40) @(posedge clock);
    for (i = 0; i < 300; i++) begin
      @(negedge clock);
      seen = seen | {tx_serial_oe & tx_serial_out_pin, tx_serial_oe};
    end
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    check(32'(tx ? q[1] : q[0]), 32'(c.exp[0]));
    if (tx) check(32'(seen[0]), 32'(c.exp[1]));
    if (tx) check(32'(seen[1]), 32'(c.exp[1]));
  endtask
  initial begin
    req.wstrb <= 4'hF;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, q, r);
      if (!rows[i].wr) check(q, rows[i].exp);
      check(32'(r), 32'(rows[i].resp));
    end
    // bit clock period in system clocks for each divider and input choice
    foreach (pcfg[i]) begin
      bus(1'b1, OFS_CFG, pcfg[i], q, r);
      edge_wait(n);
      edge_wait(n);
      edge_wait(n);
      check(32'(n), 32'(pexp[i]));
    end
    @(negedge src_clk);
    edge_wait(n);
    check(32'(n < 6), 32'h1);
    // alignment only with resync on and only after frame sync
    bus(1'b1, OFS_CFG, 32'h400000, q, r);
    fs_pulse();
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    check(32'(q[3]), 32'h0);
    bus(1'b1, OFS_CFG, 32'hC00000, q, r);
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    check(32'(q[3]), 32'h0);
    fs_pulse();
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    check(32'(q[3]), 32'h1);
    // one-word frames of 8 bits from the internal frame sync
    bus(1'b1, OFS_CFG, 32'h02080080, q, r);
    foreach (rxc[i]) run_case(1'b0, rxc[i]);
    bus(1'b1, OFS_CFG, 32'h03080080, q, r);
    foreach (txc[i]) run_case(1'b1, txc[i]);
    // mid-run reset brings status back to its reset value
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0, q, r);
    check(q, 32'h6);
    summarize();
  end
endmodule

// file: src/tdmsp_pkg.sv
// shared constants, register layouts and carrier structs of the tdm serial port
package tdmsp_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_CFG     = 8'h00;
  localparam logic [7:0]  OFS_RX_MC   = 8'h04;
  localparam logic [7:0]  OFS_TX_MC   = 8'h08;
  localparam logic [7:0]  OFS_RX_CHEN = 8'h0C;
  localparam logic [7:0]  OFS_TX_CHEN = 8'h10;
  localparam logic [7:0]  OFS_RX_DATA = 8'h14;
  localparam logic [7:0]  OFS_TX_DATA = 8'h18;
  localparam logic [7:0]  OFS_STATUS  = 8'h1C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // synchroniser lanes of the pin inputs
  localparam int          PIN_SRC     = 0;
  localparam int          PIN_FS      = 1;
  localparam int          PIN_SCK     = 2;
  localparam int          PIN_RXD     = 3;
  // transmit multichannel modes
  localparam logic [1:0]  TXM_ALL     = 2'h0;
  localparam logic [1:0]  TXM_SEL     = 2'h1;
  localparam logic [1:0]  TXM_MASKED  = 2'h2;
  localparam logic [1:0]  TXM_SYMM    = 2'h3;
  localparam logic        RST_TX_READY = 1'b1;
  localparam logic        RST_TX_EMPTY = 1'b1;

  // configuration register, bit 0 is frame_length_words lsb
  typedef struct packed {
    logic       rx_clock_mode;
    logic       tx_clock_mode;
    logic       clock_resync_enable;
    logic       generator_input_select;
    logic       source_clock_edge_polarity;
    logic       frame_sync_polarity;
    logic       frame_sync_source;
    logic [1:0] first_bit_delay;
    logic [1:0] word_length_code;
    logic [7:0] bit_clock_divider;
    logic [6:0] frame_length_words;
  } tdmsp_cfg_t;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic [1:0] rx_part_b_block_sel;
    logic [1:0] rx_part_a_block_sel;
    logic [2:0] rx_current_block;
    logic       rsvd_lo;
    logic       rx_multichannel_enable;
  } tdmsp_rx_mc_t;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic [1:0] tx_part_a_block_sel;
    logic [1:0] tx_part_b_block_sel;
    logic [2:0] tx_current_block;
    logic [1:0] tx_multichannel_mode;
  } tdmsp_tx_mc_t;

  typedef struct packed {
    logic [27:0] rsvd;
    logic        clock_aligned;
    logic        tx_shift_empty_flag;
    logic        tx_ready_flag;
    logic        rx_ready_flag;
  } tdmsp_status_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } tdmsp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tdmsp_axi_rsp_t;

  // framing position of one direction
  typedef struct packed {
    logic       active;
    logic [1:0] delay;
    logic [4:0] bit_idx;
    logic [6:0] word_idx;
    logic       fs_prev;
  } tdmsp_dir_t;

  typedef struct packed {
    tdmsp_dir_t nxt;
    logic       proc;
    logic       last;
    logic [4:0] bit_pos;
    logic [6:0] word_pos;
  } tdmsp_step_t;

  typedef struct packed {
    tdmsp_cfg_t        cfg;
    tdmsp_rx_mc_t      rxmc;
    tdmsp_tx_mc_t      txmc;
    logic [31:0]       rx_chen;
    logic [31:0]       tx_chen;
    logic [31:0]       rx_data;
    logic [31:0]       tx_data;
    logic [31:0]       rx_shift;
    logic [31:0]       tx_word;
    logic              rx_ready;
    logic              tx_ready;
    logic              tx_empty;
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        sync3;
    logic [7:0]        div_cnt;
    logic              aligned;
    logic              fs_at_rise;
    logic              regen_fs;
    logic              regen_seen;
    logic              gen_fs;
    logic [12:0]       frame_cnt;
    tdmsp_dir_t        rx;
    tdmsp_dir_t        tx;
    logic              dout;
    logic              doe;
    logic              gclk;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    tdmsp_axi_rsp_t    rsp;
  } tdmsp_state_t;
endpackage

// file: src/tdmsp_top.sv
// tdm serial port: clock generator, framing, multichannel gating and axi4-lite registers
// What this block does
// RULE1 - clock mode bit picks generator shift clock
// RULE2 - resync aligns bit clock on frame sync
// RULE3 - regenerated frame sync spans one bit; the code holds it high for two bits, until the second tick
// RULE4 - input select takes external source clock
// RULE5 - edge polarity picks falling or rising edge
// RULE6 - divider zero undivided, one halves
// RULE7 - frame sync polarity one means active low
// RULE8 - frame length field is words minus one
// RULE9 - word length code zero gives 8 bits
// RULE10 - first bit delay zero to three bits
// RULE11 - no resync lets bit clock free run
// RULE12 - external frame sync taken when source zero
// RULE13 - frame sync sampled on rising source edge
// RULE14 - channels are words of single-phase frame
// RULE15 - at most 32 of 128 channels enabled
// RULE16 - disabled receive word: no copy, no flag
// RULE17 - disabled transmit word: hi-z, no copy
// RULE18 - masked transmit channel drives hi-z
// RULE19 - receive partition b block select field
// RULE20 - receive partition a block select field
// RULE21 - receive current block field reports block
// RULE22 - receive enable clear enables all channels
// RULE23 - eight blocks of sixteen, even a odd b
// RULE24 - transmit mode zero drives every word
// RULE25 - bit clock is source over divider plus one
// RULE26 - current block follows block boundary crossing
module tdmsp_top (
  input  logic                     clock,
  input  logic                     rst_n,
  input  tdmsp_pkg::tdmsp_axi_req_t axi_req,
  output tdmsp_pkg::tdmsp_axi_rsp_t axi_rsp,
  input  logic                     external_source_clock,
  input  logic                     shift_clock_pin,
  input  logic                     rx_frame_sync_pin,
  input  logic                     rx_serial_in_pin,
  output logic                     tx_serial_out_pin,
  output logic                     tx_serial_oe,
  output logic                     generated_bit_clock
);
  import tdmsp_pkg::*;

  tdmsp_state_t st;
  tdmsp_state_t next_st;

  // one bit-clock step of a direction's framing position
  function automatic tdmsp_step_t tdmsp_step(tdmsp_dir_t d, logic tick, logic fs,
                                             logic [1:0] dly, logic [6:0] flen,
                                             logic [5:0] wb);
    tdmsp_step_t s;
    s     = '0;
    s.nxt = d;
    if (tick) begin
      s.nxt.fs_prev = fs;
      if (fs && !d.fs_prev) begin
        s.nxt.active   = 1'b1;
        s.nxt.bit_idx  = 5'h00;
        s.nxt.word_idx = 7'h00;
        s.proc         = (dly == 2'h0); // RULE10
        s.nxt.delay    = (dly == 2'h0) ? 2'h0 : 2'(dly - 2'h1); // RULE10
      end else if (d.active) begin
        if (d.delay != 2'h0) begin
          s.nxt.delay = 2'(d.delay - 2'h1);
        end else begin
          s.proc = 1'b1;
        end
      end
      if (s.proc) begin
        s.bit_pos  = s.nxt.bit_idx;
        s.word_pos = s.nxt.word_idx;
        s.last     = ({1'b0, s.bit_pos} == 6'(wb - 6'h01));
        if (s.last) begin
          s.nxt.bit_idx = 5'h00;
          // field holds words minus one
          if (s.word_pos == flen) begin // RULE8
            s.nxt.active = 1'b0;
          end else begin
            s.nxt.word_idx = 7'(s.word_pos + 7'h01);
          end
        end else begin
          s.nxt.bit_idx = 5'(s.bit_pos + 5'h01);
        end
      end
    end
    return s;
  endfunction

  // channel selected through its partition block and enable bit
  function automatic logic tdmsp_chan_on(logic [6:0] ch, logic [1:0] blk_a, logic [1:0] blk_b,
                                         logic [31:0] en);
    logic [2:0] blk;
    blk = ch[6:4]; // RULE23
    // only two blocks can match, so at most 32 channels pass
    return (blk[0] ? (blk[2:1] == blk_b) : (blk[2:1] == blk_a)) && en[{blk[0], ch[3:0]}]; // RULE15
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] tdmsp_merge(logic [31:0] old, logic [31:0] wd,
                                              logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic        src_rise;
  logic        src_edge;
  logic        gen_in;
  logic        gen_tick;
  logic        pin_tick;
  logic        rx_tick;
  logic        tx_tick;
  logic        ext_act;
  logic        realign;
  logic        fs_int;
  logic [5:0]  wb;
  logic [12:0] fbits;
  tdmsp_step_t rs;
  tdmsp_step_t ts;
  logic        rx_en;
  logic        tx_en;
  logic        tx_unm;
  logic        tx_sel;
  logic        copy;
  logic [31:0] tx_src;
  logic [31:0] merged;
  logic [31:0] rd;
  logic [31:0] shifted;
  logic [1:0]  rresp;

  // next-state logic of the whole block
  always_comb begin
    next_st = st;
    // pins pass two flops; the third stage only feeds edge detection
    next_st.sync1 = {rx_serial_in_pin, shift_clock_pin, rx_frame_sync_pin, external_source_clock};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    wb    = 6'({st.cfg.word_length_code, 3'h0} + 6'h08); // RULE9
    fbits = 13'((13'(st.cfg.frame_length_words) + 13'h0001) * 13'(wb));

    // source clock edges, falling edge chosen by polarity one
    src_rise = !st.sync3[PIN_SRC] && st.sync2[PIN_SRC];
    src_edge = st.cfg.source_clock_edge_polarity ?
               (st.sync3[PIN_SRC] && !st.sync2[PIN_SRC]) : src_rise; // RULE5
    gen_in   = st.cfg.generator_input_select ? src_edge : 1'b1; // RULE4
    pin_tick = st.sync3[PIN_SCK] && !st.sync2[PIN_SCK];
    ext_act  = st.sync2[PIN_FS] ^ st.cfg.frame_sync_polarity; // RULE7

    // resync samples the external frame sync on rising source edges; framing takes ext_act unsampled
    realign = 1'b0;
    if (src_rise) begin
      next_st.fs_at_rise = ext_act; // RULE13
      realign = st.cfg.clock_resync_enable && ext_act && !st.fs_at_rise; // RULE2 RULE13
    end

    // divider: one tick per (divider + 1) generator input events
    gen_tick = 1'b0;
    if (realign) begin
      next_st.div_cnt    = 8'h00; // RULE2
      next_st.aligned    = 1'b1;
      next_st.regen_fs   = 1'b1; // RULE3
      next_st.regen_seen = 1'b0;
    end else if (gen_in) begin
      if (st.div_cnt >= st.cfg.bit_clock_divider) begin
        next_st.div_cnt = 8'h00; // RULE6 RULE25
        gen_tick        = 1'b1;
      end else begin
        next_st.div_cnt = 8'(st.div_cnt + 8'h01); // RULE25
      end
    end
    if (!st.cfg.clock_resync_enable) begin
      next_st.aligned = 1'b0; // RULE11
    end

    // regenerated frame sync stays up across two whole bits, so two ticks see it
    if (gen_tick && st.regen_fs) begin
      next_st.regen_seen = 1'b1;
      if (st.regen_seen) begin
        next_st.regen_fs = 1'b0; // RULE3
      end
    end

    // internal frame sync generator, one bit wide per frame
    if (gen_tick) begin
      if (st.frame_cnt >= 13'(fbits - 13'h0001)) begin
        next_st.frame_cnt = 13'h0000;
        next_st.gen_fs    = 1'b1;
      end else begin
        next_st.frame_cnt = 13'(st.frame_cnt + 13'h0001);
        next_st.gen_fs    = 1'b0;
      end
    end

    // bit clock output: the external source or gen_tick when undivided, else a duty count
    if (st.cfg.bit_clock_divider == 8'h00) begin
      next_st.gclk = st.cfg.generator_input_select ?
                     (st.sync2[PIN_SRC] ^ st.cfg.source_clock_edge_polarity) : gen_tick; // RULE6
    end else begin
      next_st.gclk = (next_st.div_cnt <= (st.cfg.bit_clock_divider >> 1)); // RULE6
    end

    // frame sync source for both directions
    if (st.cfg.clock_resync_enable) begin
      fs_int = st.regen_fs; // RULE3
    end else if (st.cfg.frame_sync_source) begin
      fs_int = st.gen_fs;
    end else begin
      fs_int = ext_act; // RULE12
    end

    rx_tick = st.cfg.rx_clock_mode ? gen_tick : pin_tick; // RULE1
    tx_tick = st.cfg.tx_clock_mode ? gen_tick : pin_tick; // RULE1

    // axi4-lite handshakes
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    merged = 32'h0000_0000;
    if (st.aw_got && st.w_got && !st.rsp.bvalid) begin
      next_st.aw_got     = 1'b0;
      next_st.w_got      = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = RESP_OKAY;
      if (st.awaddr == OFS_CFG) begin
        merged      = tdmsp_merge(32'(st.cfg), st.wdata, st.wstrb);
        next_st.cfg = tdmsp_cfg_t'(merged[$bits(tdmsp_cfg_t)-1:0]);
      end else if (st.awaddr == OFS_RX_MC) begin
        merged = tdmsp_merge(32'(st.rxmc), st.wdata, st.wstrb);
        next_st.rxmc.rx_part_b_block_sel    = merged[8:7]; // RULE19
        next_st.rxmc.rx_part_a_block_sel    = merged[6:5]; // RULE20
        next_st.rxmc.rx_multichannel_enable = merged[0];
      end else if (st.awaddr == OFS_TX_MC) begin
        merged = tdmsp_merge(32'(st.txmc), st.wdata, st.wstrb);
        next_st.txmc.tx_part_a_block_sel  = merged[8:7];
        next_st.txmc.tx_part_b_block_sel  = merged[6:5];
        next_st.txmc.tx_multichannel_mode = merged[1:0];
      end else if (st.awaddr == OFS_RX_CHEN) begin
        next_st.rx_chen = tdmsp_merge(st.rx_chen, st.wdata, st.wstrb);
      end else if (st.awaddr == OFS_TX_CHEN) begin
        next_st.tx_chen = tdmsp_merge(st.tx_chen, st.wdata, st.wstrb);
      end else if (st.awaddr == OFS_TX_DATA) begin
        next_st.tx_data  = tdmsp_merge(st.tx_data, st.wdata, st.wstrb);
        next_st.tx_ready = 1'b0;
      end else if (st.awaddr == OFS_RX_DATA || st.awaddr == OFS_STATUS) begin
        next_st.rsp.bresp = RESP_OKAY;
      end else begin
        next_st.rsp.bresp = RESP_SLVERR;
      end
    end
    next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
    next_st.rsp.wready  = !next_st.w_got && !next_st.rsp.bvalid;

    // read decode
    rd    = 32'h0000_0000;
    rresp = RESP_OKAY;
    if (axi_req.araddr == OFS_CFG) begin
      rd = 32'(st.cfg);
    end else if (axi_req.araddr == OFS_RX_MC) begin
      rd = 32'(st.rxmc); // RULE21
    end else if (axi_req.araddr == OFS_TX_MC) begin
      rd = 32'(st.txmc);
    end else if (axi_req.araddr == OFS_RX_CHEN) begin
      rd = st.rx_chen;
    end else if (axi_req.araddr == OFS_TX_CHEN) begin
      rd = st.tx_chen;
    end else if (axi_req.araddr == OFS_RX_DATA) begin
      rd = st.rx_data;
    end else if (axi_req.araddr == OFS_TX_DATA) begin
      rd = st.tx_data;
    end else if (axi_req.araddr == OFS_STATUS) begin
      rd = 32'(tdmsp_status_t'({28'h0000000, st.aligned, st.tx_empty, st.tx_ready,
                                st.rx_ready}));
    end else begin
      rresp = RESP_SLVERR;
    end
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata  = rd;
      next_st.rsp.rresp  = rresp;
      if (axi_req.araddr == OFS_RX_DATA) begin
        next_st.rx_ready = 1'b0;
      end
    end
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // receive path; a new word outranks a clearing read
    rs         = tdmsp_step(st.rx, rx_tick, fs_int, st.cfg.first_bit_delay,
                            st.cfg.frame_length_words, wb);
    next_st.rx = rs.nxt;
    rx_en      = !st.rxmc.rx_multichannel_enable ||
                 tdmsp_chan_on(rs.word_pos, st.rxmc.rx_part_a_block_sel,
                               st.rxmc.rx_part_b_block_sel, st.rx_chen); // RULE22 RULE14
    shifted    = {st.rx_shift[30:0], st.sync2[PIN_RXD]};
    if (rs.proc) begin
      next_st.rx_shift              = shifted;
      next_st.rxmc.rx_current_block = rs.word_pos[6:4]; // RULE21 RULE26
      if (rs.last && rx_en) begin
        next_st.rx_data  = shifted & (32'hFFFF_FFFF >> (6'h20 - wb)); // RULE16
        next_st.rx_ready = 1'b1; // RULE16
      end
    end

    // transmit enable and mask per multichannel mode
    ts         = tdmsp_step(st.tx, tx_tick, fs_int, st.cfg.first_bit_delay,
                            st.cfg.frame_length_words, wb);
    next_st.tx = ts.nxt;
    tx_sel     = tdmsp_chan_on(ts.word_pos, st.txmc.tx_part_a_block_sel,
                               st.txmc.tx_part_b_block_sel, st.tx_chen);
    case (st.txmc.tx_multichannel_mode)
      TXM_ALL: begin
        tx_en  = 1'b1; // RULE24
        tx_unm = 1'b1; // RULE24
      end
      TXM_SEL: begin
        tx_en  = tx_sel;
        tx_unm = tx_sel;
      end
      TXM_MASKED: begin
        tx_en  = 1'b1;
        tx_unm = tx_sel;
      end
      default: begin
        tx_en  = tdmsp_chan_on(ts.word_pos, st.rxmc.rx_part_a_block_sel,
                               st.rxmc.rx_part_b_block_sel, st.rx_chen);
        tx_unm = tx_sel;
      end
    endcase

    // buffer-to-shift copy at word start; copy takes data written this cycle
    copy   = ts.proc && (ts.bit_pos == 5'h00) && tx_en; // RULE17
    tx_src = copy ? next_st.tx_data : st.tx_word;
    if (copy) begin
      next_st.tx_word  = next_st.tx_data;
      next_st.tx_empty = next_st.tx_ready; // buffer never refilled: stale word resent
      next_st.tx_ready = 1'b1;
    end
    if (ts.proc) begin
      next_st.txmc.tx_current_block = ts.word_pos[6:4];
      next_st.dout = tx_src[5'(wb - 6'h01 - {1'b0, ts.bit_pos})];
      next_st.doe  = tx_en && tx_unm; // RULE17 RULE18
    end else if (tx_tick && !st.tx.active) begin
      next_st.doe = 1'b0; // idle between frames stays hi-z
    end
  end

  // the single state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.tx_ready <= RST_TX_READY;
      st.tx_empty <= RST_TX_EMPTY;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign axi_rsp             = st.rsp;
  assign tx_serial_out_pin   = st.dout;
  assign tx_serial_oe        = st.doe;
  assign generated_bit_clock = st.gclk;
endmodule
